//--- core/hdlc_code_ds0_config.sv
// Register bank for HDLC and code word transmit / receive steering
// Operation
// - Code word sends on trigger rising edge while enable is high
// - Enable low: link bits from input pin
// - Enable high: link bits from controller, code word bits while one is sent
// - Code word bit 0 sent first
// - Code word bit 5 sent last
// - Channel mode high: receive on DS0s
// - Select low: single channel by number
// - Select high: block map, number ignored
// - Channel number bits 4..0, MSB first
// - Suppress bits drop matching DS0 bits
`timescale 1ns/1ps
module hdlc_code_ds0_config
	import hdlc_cfg_pkg::*;
#(
	parameter int NUM_CHANNELS = CHAN_COUNT
)(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [7:0] addr,
	input wire logic [7:0] wrData,
	input wire logic wrStrobe,
	input wire logic rdStrobe,
	output logic [7:0] rdData,
	input wire logic linkInputPin,
	input wire logic hdlcBitIn,
	input wire logic bitSlot,
	input wire logic [NUM_CHANNELS-1:0] rxChannelBlockMap,
	input wire logic [4:0] rxTimeslot,
	input wire logic [2:0] rxBitPos,
	output logic fdlBitOut,
	output logic [7:0] fifoByte,
	output logic fifoWrite,
	output logic rxUseDs0,
	output logic rxBitTake
);
	////////////////////////////////////////////////////////////////////
	logic [7:0] txCtl_q;
	logic [7:0] rxCtl_q;
	logic [7:0] rxSup_q;
	logic trigPrev_q;
	logic [7:0] rdData_q;
	logic fdl_q;
	logic [7:0] fifoByte_q;
	logic fifoWrite_q;
	logic rxUseDs0_q;
	logic rxBitTake_q;
	logic link1_q;
	logic link2_q;
	logic wrTx, wrFifo, wrRx, wrSup;
	logic trigRise;
	logic chanHit;
	logic bitKept;
	logic fdlNext;
	logic [7:0] rdMux;
	logic slotInMap;
	logic [2:0] sentCount_q;
	logic [5:0] sentWord_q;
	code_word_if cw();
	////////////////////////////////////////////////////////////////////
	assign wrTx = wrStrobe && (addr == TX_CODE_WORD_CONTROL_ADDR);
	assign wrFifo = wrStrobe && (addr == TX_HDLC_FIFO_DATA_ADDR);
	assign wrRx = wrStrobe && (addr == RX_HDLC_CHANNEL_CONTROL_ADDR);
	assign wrSup = wrStrobe && (addr == RX_HDLC_BIT_SUPPRESS_ADDR);
	assign trigRise = txCtl_q[SEND_TRIGGER_BIT] && !trigPrev_q;
	assign cw.start = trigRise;
	assign cw.word = txCtl_q[CODE_MSB:0];
	// Code word takes the place of HDLC data while it is being sent
	assign fdlNext = !txCtl_q[TX_ENABLE_BIT] ? link2_q :
		(cw.busy ? cw.bitOut : hdlcBitIn);
	// Single channel compare uses all five bits, bit 4 as MSB
	// Timeslots past the map width never match in block map mode
	assign slotInMap = (int'(rxTimeslot) < NUM_CHANNELS);
	assign chanHit = rxCtl_q[RX_SELECT_BIT] ?
		(slotInMap && rxChannelBlockMap[rxTimeslot]) :
		(rxTimeslot == rxCtl_q[CHAN_MSB:0]);
	// Bit position 0 is DS0 bit 1, position 7 is DS0 bit 8
	assign bitKept = !rxSup_q[rxBitPos];
	assign rdMux = (addr == TX_CODE_WORD_CONTROL_ADDR) ? txCtl_q :
		(addr == RX_HDLC_CHANNEL_CONTROL_ADDR) ? rxCtl_q :
		(addr == RX_HDLC_BIT_SUPPRESS_ADDR) ? rxSup_q : 8'h00;
	////////////////////////////////////////////////////////////////////
	code_word_serialiser u_ser (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.slot(bitSlot),
		.cw(cw.ser)
	);
	////////////////////////////////////////////////////////////////////
	// Link pin is asynchronous to the framer clock
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			link1_q <= 1'b0;
			link2_q <= 1'b0;
		end else begin
			link1_q <= linkInputPin;
			link2_q <= link1_q;
		end
	end
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			txCtl_q <= REG_RESET;
			rxCtl_q <= REG_RESET;
			rxSup_q <= REG_RESET;
			trigPrev_q <= 1'b0;
		end else begin
			trigPrev_q <= txCtl_q[SEND_TRIGGER_BIT];
			if (wrTx)
				txCtl_q <= wrData;
			if (wrRx)
				rxCtl_q <= wrData; // Bit 6 kept as written
			if (wrSup)
				rxSup_q <= wrData;
		end
	end
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			fifoByte_q <= 8'h00;
			fifoWrite_q <= 1'b0;
		end else begin
			fifoWrite_q <= wrFifo;
			if (wrFifo)
				fifoByte_q <= wrData; // Bit order kept, bit 7 MSB
		end
	end
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			fdl_q <= 1'b0;
			rxUseDs0_q <= 1'b0;
			rxBitTake_q <= 1'b0;
			rdData_q <= 8'h00;
		end else begin
			fdl_q <= fdlNext;
			rxUseDs0_q <= rxCtl_q[RX_MODE_BIT];
			// In link mode every slot bit goes to the controller
			rxBitTake_q <= rxCtl_q[RX_MODE_BIT] ?
				(chanHit && bitKept) : bitSlot;
			if (rdStrobe)
				rdData_q <= rdMux;
		end
	end
	// Reference count of code bits sent, read only by the checks below
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			sentCount_q <= 3'h0;
			sentWord_q <= 6'h00;
		end else if (cw.start) begin
			sentCount_q <= 3'h0;
			sentWord_q <= txCtl_q[CODE_MSB:0];
		end else if (cw.busy && bitSlot) begin
			sentCount_q <= sentCount_q + 3'h1;
		end
	end
	assign fdlBitOut = fdl_q;
	assign fifoByte = fifoByte_q;
	assign fifoWrite = fifoWrite_q;
	assign rxUseDs0 = rxUseDs0_q;
	assign rxBitTake = rxBitTake_q;
	assign rdData = rdData_q;
	////////////////////////////////////////////////////////////////////
	a_trigger_starts: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		$rose(txCtl_q[SEND_TRIGGER_BIT]) |-> ##1 cw.busy)
		else $error("code word did not start on trigger edge");
	// A trigger bit that stays high must not restart the word
	a_no_start_level: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		txCtl_q[SEND_TRIGGER_BIT] && $past(txCtl_q[SEND_TRIGGER_BIT])
		|-> !cw.start)
		else $error("code word started without rising edge");
	a_pin_source: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		!txCtl_q[TX_ENABLE_BIT] |=> fdlBitOut == $past(link2_q))
		else $error("link bit not from pin");
	a_ctrl_source: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		txCtl_q[TX_ENABLE_BIT] && !cw.busy |=>
		fdlBitOut == $past(hdlcBitIn))
		else $error("link bit not from controller");
	sequence s_start;
		cw.start;
	endsequence
	a_first_bit: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		s_start |=> cw.bitOut == $past(txCtl_q[0]))
		else $error("first code bit is not bit 0");
	sequence s_final_slot;
		cw.busy && bitSlot && !cw.start &&
		sentCount_q == BIT_INDEX_LAST;
	endsequence
	a_code_order: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		cw.busy |-> cw.bitOut == sentWord_q[sentCount_q])
		else $error("code bit sent out of order");
	a_six_bits: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		s_final_slot |=> !cw.busy)
		else $error("code word did not end after bit 5");
	a_word_holds: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		cw.busy && !(bitSlot && sentCount_q == BIT_INDEX_LAST)
		|=> cw.busy)
		else $error("code word ended before bit 5");
	a_fifo_byte: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		wrFifo |=> fifoWrite && fifoByte == $past(wrData))
		else $error("fifo byte not passed in order");
	a_fifo_quiet: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		!wrFifo |=> !fifoWrite)
		else $error("fifo push without a write");
	a_mode_follow: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		wrRx |=> ##1 rxUseDs0 == $past(wrData[RX_MODE_BIT], 2))
		else $error("receive mode not applied");
	a_link_take: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		!rxCtl_q[RX_MODE_BIT] |=> rxBitTake == $past(bitSlot))
		else $error("link mode does not take every slot");
	a_single_chan: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		rxCtl_q[RX_MODE_BIT] && !rxCtl_q[RX_SELECT_BIT] &&
		rxTimeslot != rxCtl_q[CHAN_MSB:0] |=> !rxBitTake)
		else $error("bit taken from wrong channel");
	a_chan_number: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		rxCtl_q[RX_MODE_BIT] && !rxCtl_q[RX_SELECT_BIT] &&
		rxTimeslot == rxCtl_q[CHAN_MSB:0] &&
		!rxSup_q[rxBitPos] |=> rxBitTake)
		else $error("named channel bit not taken");
	a_block_map: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		rxCtl_q[RX_MODE_BIT] && rxCtl_q[RX_SELECT_BIT] &&
		!rxChannelBlockMap[rxTimeslot] |=> !rxBitTake)
		else $error("bit taken outside block map");
	a_map_hit: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		rxCtl_q[RX_MODE_BIT] && rxCtl_q[RX_SELECT_BIT] &&
		slotInMap && rxChannelBlockMap[rxTimeslot] &&
		!rxSup_q[rxBitPos] |=> rxBitTake)
		else $error("mapped channel bit not taken");
	a_suppress: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		rxCtl_q[RX_MODE_BIT] && rxSup_q[rxBitPos] |=> !rxBitTake)
		else $error("suppressed bit was taken");
endmodule

//--- core/hdlc_cfg_pkg.sv
// Package with register map, field positions and reset values
package hdlc_cfg_pkg;
	localparam logic [7:0] TX_CODE_WORD_CONTROL_ADDR = 8'h07;
	localparam logic [7:0] TX_HDLC_FIFO_DATA_ADDR = 8'h08;
	localparam logic [7:0] RX_HDLC_CHANNEL_CONTROL_ADDR = 8'h90;
	localparam logic [7:0] RX_HDLC_BIT_SUPPRESS_ADDR = 8'h91;
	localparam int SEND_TRIGGER_BIT = 7;
	localparam int TX_ENABLE_BIT = 6;
	localparam int CODE_MSB = 5;
	localparam int CODE_WIDTH = 6;
	localparam int RX_MODE_BIT = 7;
	localparam int RX_UNUSED_BIT = 6;
	localparam int RX_SELECT_BIT = 5;
	localparam int CHAN_MSB = 4;
	localparam int CHAN_COUNT = 24;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [2:0] BIT_INDEX_LAST = 3'h5;
endpackage

//--- core/code_word_if.sv
// Interface between register bank and code word serialiser
`timescale 1ns/1ps
interface code_word_if;
	logic start;
	logic [5:0] word;
	logic bitOut;
	logic busy;
	modport bank(output start, output word, input bitOut, input busy);
	modport ser(input start, input word, output bitOut, output busy);
endinterface

//--- core/code_word_serialiser.sv
// Shifts the six-bit code word out, bit 0 first, one bit per slot
`timescale 1ns/1ps
module code_word_serialiser
	import hdlc_cfg_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic slot,
	code_word_if.ser cw
);
	logic [5:0] shift_q;
	logic [2:0] idx_q;
	logic busy_q;
	logic lastBit;
	assign lastBit = (idx_q == BIT_INDEX_LAST);
	assign cw.bitOut = shift_q[0];
	assign cw.busy = busy_q;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			shift_q <= 6'h00;
			idx_q <= 3'h0;
			busy_q <= 1'b0;
		end else if (cw.start) begin
			shift_q <= cw.word; // Bit 0 leads
			idx_q <= 3'h0;
			busy_q <= 1'b1;
		end else if (busy_q && slot) begin
			shift_q <= {1'b0, shift_q[5:1]};
			idx_q <= idx_q + 3'h1;
			busy_q <= !lastBit; // Bit 5 is the final one
		end
	end
endmodule

//--- test/hdlc_code_ds0_config_bench.sv
// Self-checking bench for the HDLC code word and DS0 steering registers
`timescale 1ns/1ps
module hdlc_code_ds0_config_bench;
	import hdlc_cfg_pkg::*;
	logic sys_clk, nrst, wrStrobe, rdStrobe, linkInputPin, hdlcBitIn, bitSlot;
	logic [7:0] addr, wrData, rdData, fifoByte;
	logic [23:0] rxChannelBlockMap;
	logic [4:0] rxTimeslot;
	logic [2:0] rxBitPos;
	logic fdlBitOut, fifoWrite, rxUseDs0, rxBitTake;
	int fails = 0, checked = 0, cycles = 0;
	hdlc_code_ds0_config #(.NUM_CHANNELS(24)) dut(.sys_clk(sys_clk),
		.nrst(nrst), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
		.rdStrobe(rdStrobe), .rdData(rdData), .linkInputPin(linkInputPin),
		.hdlcBitIn(hdlcBitIn), .bitSlot(bitSlot),
		.rxChannelBlockMap(rxChannelBlockMap), .rxTimeslot(rxTimeslot),
		.rxBitPos(rxBitPos), .fdlBitOut(fdlBitOut), .fifoByte(fifoByte),
		.fifoWrite(fifoWrite), .rxUseDs0(rxUseDs0), .rxBitTake(rxBitTake));
	////////////////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	// Ceiling far above the roughly 135 cycles the tests need
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			fails++;
			give_verdict();
		end
	end
	task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		addr = a;
		wrData = d;
		wrStrobe = 1'b1;
		cyc(1);
		wrStrobe = 1'b0;
		cyc(1);
	endtask
	task automatic rd_chk(logic [7:0] a, logic [7:0] exp);
		addr = a;
		rdStrobe = 1'b1;
		cyc(1);
		rdStrobe = 1'b0;
		chk("readback", exp, rdData);
		cyc(1);
	endtask
	task automatic slot_pulse();
		bitSlot = 1'b1;
		cyc(1);
		bitSlot = 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic test_regs();
		rd_chk(TX_CODE_WORD_CONTROL_ADDR, REG_RESET);
		rd_chk(RX_HDLC_BIT_SUPPRESS_ADDR, REG_RESET);
		wr(RX_HDLC_CHANNEL_CONTROL_ADDR, 8'h3A);
		rd_chk(RX_HDLC_CHANNEL_CONTROL_ADDR, 8'h3A);
		wr(RX_HDLC_BIT_SUPPRESS_ADDR, 8'h5C);
		rd_chk(RX_HDLC_BIT_SUPPRESS_ADDR, 8'h5C);
		wr(8'h55, 8'hFF);
		rd_chk(8'h55, 8'h00);
		rd_chk(TX_HDLC_FIFO_DATA_ADDR, 8'h00);
		$display("test_regs done");
	endtask
	task automatic test_code_word();
		logic [5:0] code = 6'h25;
		hdlcBitIn = 1'b0;
		wr(TX_CODE_WORD_CONTROL_ADDR, {2'b11, code});
		cyc(3);
		for (int i = 0; i < CODE_WIDTH; i++) begin
			chk("code bit", {7'h00, code[i]}, {7'h00, fdlBitOut});
			slot_pulse();
			cyc(3);
		end
		chk("after code", 8'h00, {7'h00, fdlBitOut});
		wr(TX_CODE_WORD_CONTROL_ADDR, {2'b11, code});
		cyc(4);
		chk("no resend", 8'h00, {7'h00, fdlBitOut});
		$display("test_code_word done");
	endtask
	task automatic test_link_source();
		wr(TX_CODE_WORD_CONTROL_ADDR, 8'h00);
		for (int i = 0; i < 2; i++) begin
			linkInputPin = i[0];
			hdlcBitIn = ~i[0];
			cyc(5);
			chk("pin link", {7'h00, i[0]}, {7'h00, fdlBitOut});
		end
		wr(TX_CODE_WORD_CONTROL_ADDR, 8'h40);
		cyc(3);
		chk("ctl link", {7'h00, hdlcBitIn}, {7'h00, fdlBitOut});
		$display("test_link_source done");
	endtask
	task automatic test_fifo();
		// Byte is not a bit palindrome, so a reversed order shows
		addr = TX_HDLC_FIFO_DATA_ADDR;
		wrData = 8'h1E;
		wrStrobe = 1'b1;
		cyc(1);
		wrStrobe = 1'b0;
		chk("fifo push", 8'h01, {7'h00, fifoWrite});
		chk("fifo byte", 8'h1E, fifoByte);
		cyc(1);
		chk("fifo pulse", 8'h00, {7'h00, fifoWrite});
		$display("test_fifo done");
	endtask
	task automatic rx_sweep(logic [7:0] sup, logic [4:0] hit);
		for (int t = 3; t < 6; t++) begin
			for (int p = 0; p < 8; p++) begin
				rxTimeslot = t[4:0];
				rxBitPos = p[2:0];
				cyc(1);
				chk("bit take", {7'h00, t[4:0] == hit && !sup[p]},
					{7'h00, rxBitTake});
			end
		end
	endtask
	task automatic test_receive();
		wr(RX_HDLC_CHANNEL_CONTROL_ADDR, 8'h00);
		chk("use ds0", 8'h00, {7'h00, rxUseDs0});
		bitSlot = 1'b1;
		cyc(1);
		bitSlot = 1'b0;
		chk("link take", 8'h01, {7'h00, rxBitTake});
		wr(RX_HDLC_BIT_SUPPRESS_ADDR, 8'h81);
		wr(RX_HDLC_CHANNEL_CONTROL_ADDR, 8'h85);
		chk("use ds0", 8'h01, {7'h00, rxUseDs0});
		rx_sweep(8'h81, 5'h05);
		rxChannelBlockMap = 24'h000008;
		wr(RX_HDLC_CHANNEL_CONTROL_ADDR, 8'hA5);
		rx_sweep(8'h81, 5'h03);
		$display("test_receive done");
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		nrst = 1'b0;
		{wrStrobe, rdStrobe, linkInputPin, hdlcBitIn, bitSlot} = 5'h00;
		addr = 8'h00;
		wrData = 8'h00;
		rxChannelBlockMap = 24'h000000;
		rxTimeslot = 5'h00;
		rxBitPos = 3'h0;
		cyc(5);
		nrst = 1'b1;
		cyc(1);
		test_regs();
		test_code_word();
		test_link_source();
		test_fifo();
		test_receive();
		give_verdict();
	end
endmodule
